// File: logic/lrmon_top.sv
// Link reliability monitor top: AHB-Lite registers, error and period tallies.
// Summary of operation
// - Tallies count whatever the enable bit; the flag and the tally freeze need it at one; it is sticky and resets to zero.
// - With the error-type bit at zero, received LCRC failures are the counted events.
// - With the error-type bit at one, L0-to-Recovery moves caused by link faults are counted.
// - Counted causes are clock compensation errors, electrical idle, deskew errors and link errors.
// - Only Recovery entries that this port starts are counted, not partner-started ones.
// - The unreliable-link flag sets when the error tally reaches the threshold.
// - The flag sets only while monitoring is enabled.
// - Only a software write of one clears the flag; hardware never does; it resets to zero.
// - A 24-bit sticky monitoring period in microseconds sets the window; zero is reserved.
// - Tallies saturate, stop once the link is unreliable, and clear on retrain, Detect or enable rise.
// - Both tallies restart when the period tally equals the period, even while disabled.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lrmon_top (
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	input  wire logic        i_sticky_reset_n,
	input  wire logic        i_ce,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic [31:0]      o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	input  wire logic        i_lcrc_err,
	input  wire logic        i_rec_entry,
	input  wire logic        i_rec_local,
	input  wire logic [3:0]  i_rec_cause,
	input  wire logic        i_retrain_req,
	input  wire logic        i_in_detect,
	output logic             o_unreliable_link
);
	import lrmon_pkg::*;

	// ===========================================================
	// Bus address phase capture
	logic                    wr_pend_r;
	logic                    wr_pend_nxt;
	logic [LRMON_ADDR_W-1:0] wr_addr_r;
	logic [LRMON_ADDR_W-1:0] wr_addr_nxt;
	logic [31:0]             rdata_r;
	logic [31:0]             rdata_nxt;
	logic                    addr_ok;

	// Sticky configuration and flag.
	logic                    enable_r;
	logic                    enable_nxt;
	logic                    err_type_r;
	logic                    err_type_nxt;
	logic [LRMON_THR_W-1:0]  error_threshold_r;
	logic [LRMON_THR_W-1:0]  error_threshold_nxt;
	logic [LRMON_PER_W-1:0]  period_r;
	logic [LRMON_PER_W-1:0]  period_nxt;
	logic                    unreliable_link_flag_r;
	logic                    unreliable_link_flag_nxt;

	// Tallies (non-sticky).
	logic [LRMON_THR_W-1:0]  error_tally_r;
	logic [LRMON_THR_W-1:0]  error_tally_nxt;
	logic [LRMON_PER_W-1:0]  window_time_tally_r;
	logic [LRMON_PER_W-1:0]  window_time_tally_nxt;
	logic                    enable_d_r;
	logic                    judged_r;
	logic                    judged_nxt;

	logic                    us_tick;
	logic                    err_event;
	logic                    tally_clear;
	logic                    wr_ctrl;
	logic                    wr_stat;
	logic                    wr_thr;

	function automatic logic [LRMON_THR_W-1:0] sat_inc8(input logic [LRMON_THR_W-1:0] v);
		sat_inc8 = (v == LRMON_ERR_MAX) ? v : v + 8'h01;
	endfunction

	function automatic logic [LRMON_PER_W-1:0] sat_inc24(input logic [LRMON_PER_W-1:0] v);
		sat_inc24 = (v == LRMON_PER_MAX) ? v : v + 24'h00_0001;
	endfunction

	// ===========================================================
	// Helper blocks
	lrmon_us_tick u_tick (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.i_restart (tally_clear),
		.o_tick    (us_tick)
	);

	lrmon_evt_sel u_evt (
		.i_mclk            (i_mclk),
		.i_reset_n         (i_reset_n),
		.i_ce              (i_ce),
		.i_link_state_mode (err_type_r),
		.i_lcrc_err        (i_lcrc_err),
		.i_rec_entry       (i_rec_entry),
		.i_rec_local       (i_rec_local),
		.i_rec_cause       (i_rec_cause),
		.o_event           (err_event)
	);

	// ===========================================================
	// AHB-Lite slave: zero wait states, always OKAY.
	assign addr_ok = i_hsel && i_hready && i_htrans[1];

	always_comb begin
		wr_pend_nxt = addr_ok && i_hwrite;
		wr_addr_nxt = i_haddr[LRMON_ADDR_W-1:0];
		rdata_nxt   = rdata_r;
		if (addr_ok && !i_hwrite) begin
			unique case (i_haddr[LRMON_ADDR_W-1:0])
				LRMON_CTRL_OFS: begin
					rdata_nxt = {30'h0, err_type_r, enable_r};
				end
				LRMON_STAT_OFS: begin
					rdata_nxt = {31'h0, unreliable_link_flag_r};
				end
				LRMON_THRESH_OFS: begin
					rdata_nxt = {period_r, error_threshold_r};
				end
				LRMON_CNT_OFS: begin
					rdata_nxt = {window_time_tally_r, error_tally_r};
				end
				default: begin
					rdata_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
			rdata_r   <= 32'h0000_0000;
		end else if (i_ce) begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	assign o_hrdata    = rdata_r;
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	assign wr_ctrl = wr_pend_r && (wr_addr_r == LRMON_CTRL_OFS);
	assign wr_stat = wr_pend_r && (wr_addr_r == LRMON_STAT_OFS);
	assign wr_thr  = wr_pend_r && (wr_addr_r == LRMON_THRESH_OFS);

	// ===========================================================
	// Sticky registers: kept across ordinary reset, cleared by sticky reset.
	always_comb begin
		enable_nxt          = enable_r;
		err_type_nxt        = err_type_r;
		error_threshold_nxt = error_threshold_r;
		period_nxt          = period_r;
		if (wr_ctrl) begin
			enable_nxt   = i_hwdata[LRMON_EN_BIT];
			err_type_nxt = i_hwdata[LRMON_TYPE_BIT];
		end
		if (wr_thr) begin
			error_threshold_nxt = i_hwdata[LRMON_THR_LSB +: LRMON_THR_W];
			period_nxt          = i_hwdata[LRMON_PER_LSB +: LRMON_PER_W];
		end
		unreliable_link_flag_nxt = unreliable_link_flag_r;
		// Write one clears; a same-cycle detection wins so no event is lost.
		if (wr_stat && i_hwdata[LRMON_ULF_BIT]) begin
			unreliable_link_flag_nxt = 1'b0;
		end
		// A tally left from the disabled time is no match: the enable rise clears
		// it in the same cycle, so that first enabled cycle must not set the flag.
		if (enable_r && enable_d_r && (error_tally_r >= error_threshold_r)) begin
			unreliable_link_flag_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_sticky_reset_n) begin
		if (!i_sticky_reset_n) begin
			enable_r               <= 1'b0;
			err_type_r             <= 1'b0;
			error_threshold_r      <= LRMON_THR_RST;
			period_r               <= LRMON_PER_RST;
			unreliable_link_flag_r <= 1'b0;
		end else if (i_ce) begin
			enable_r               <= enable_nxt;
			err_type_r             <= err_type_nxt;
			error_threshold_r      <= error_threshold_nxt;
			period_r               <= period_nxt;
			unreliable_link_flag_r <= unreliable_link_flag_nxt;
		end
	end

	assign o_unreliable_link = unreliable_link_flag_r;

	// ===========================================================
	// Error and window tallies.
	// Judged freezes the tallies once the threshold is met while enabled,
	// so software reading the counter sees the count that tripped it.
	assign tally_clear = i_retrain_req || i_in_detect || (enable_r && !enable_d_r);

	always_comb begin
		error_tally_nxt       = error_tally_r;
		window_time_tally_nxt = window_time_tally_r;
		judged_nxt            = judged_r;
		if (tally_clear) begin
			error_tally_nxt       = '0;
			window_time_tally_nxt = '0;
			judged_nxt            = 1'b0;
		end else if (!judged_r) begin
			if (enable_r && (error_tally_r >= error_threshold_r)) begin
				judged_nxt = 1'b1;
			end else if (window_time_tally_r == period_r) begin
				error_tally_nxt       = '0;
				window_time_tally_nxt = '0;
			end else begin
				if (err_event) begin
					error_tally_nxt = sat_inc8(error_tally_r);
				end
				if (us_tick) begin
					window_time_tally_nxt = sat_inc24(window_time_tally_r);
				end
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			error_tally_r       <= '0;
			window_time_tally_r <= '0;
			enable_d_r          <= 1'b0;
			judged_r            <= 1'b0;
		end else if (i_ce) begin
			error_tally_r       <= error_tally_nxt;
			window_time_tally_r <= window_time_tally_nxt;
			enable_d_r          <= enable_r;
			judged_r            <= judged_nxt;
		end
	end
endmodule
`default_nettype wire

// File: logic/lrmon_pkg.sv
// Package of constants for the link reliability monitor.
package lrmon_pkg;
	// ===========================================================
	// Register map
	localparam logic [11:0] LRMON_CTRL_OFS   = 12'h560;
	localparam logic [11:0] LRMON_STAT_OFS   = 12'h564;
	localparam logic [11:0] LRMON_THRESH_OFS = 12'h568;
	localparam logic [11:0] LRMON_CNT_OFS    = 12'h56c;
	localparam logic [11:0] LRMON_EVT_OFS    = 12'h570;
	localparam int          LRMON_ADDR_W     = 12;
	// ===========================================================
	// Field positions
	localparam int LRMON_EN_BIT   = 0;
	localparam int LRMON_TYPE_BIT = 1;
	localparam int LRMON_ULF_BIT  = 0;
	localparam int LRMON_THR_LSB  = 0;
	localparam int LRMON_THR_W    = 8;
	localparam int LRMON_PER_LSB  = 8;
	localparam int LRMON_PER_W    = 24;
	// ===========================================================
	// Reset values
	localparam logic [7:0]  LRMON_THR_RST  = 8'hff;
	localparam logic [23:0] LRMON_PER_RST  = 24'hff_ffff;
	localparam logic [7:0]  LRMON_ERR_MAX  = 8'hff;
	localparam logic [23:0] LRMON_PER_MAX  = 24'hff_ffff;
	// ===========================================================
	// Timing
	localparam int LRMON_CLK_MHZ   = 200;
	localparam int LRMON_US_NS     = 1000;
	localparam int LRMON_CLK_NS    = 5;
	localparam int LRMON_US_CYCLES = LRMON_US_NS / LRMON_CLK_NS;
	localparam int LRMON_PRE_W     = 8;
	localparam logic [7:0] LRMON_PRE_LAST = 8'(LRMON_US_CYCLES - 1);
	// ===========================================================
	// AHB-Lite encodings
	localparam logic [1:0] LRMON_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] LRMON_HTRANS_SEQ    = 2'h3;
	// ===========================================================
	// Recovery causes
	typedef enum logic [1:0] {
		LRMON_CAUSE_CLKCOMP,
		LRMON_CAUSE_EIDLE,
		LRMON_CAUSE_DESKEW,
		LRMON_CAUSE_DLL
	} lrmon_cause_t;
endpackage

// File: logic/lrmon_us_tick.sv
// Microsecond tick generator for the link reliability monitor.
`timescale 1ns/1ps
`default_nettype none
module lrmon_us_tick (
	input  wire logic i_mclk,
	input  wire logic i_reset_n,
	input  wire logic i_ce,
	input  wire logic i_restart,
	output logic      o_tick
);
	import lrmon_pkg::*;

	logic [LRMON_PRE_W-1:0] pre_r;
	logic [LRMON_PRE_W-1:0] pre_nxt;
	logic                   tick_r;
	logic                   tick_nxt;

	always_comb begin
		tick_nxt = 1'b0;
		pre_nxt  = pre_r + 8'h01;
		if (i_restart) begin
			pre_nxt = '0;
		end else if (pre_r == LRMON_PRE_LAST) begin
			pre_nxt  = '0;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pre_r  <= '0;
			tick_r <= 1'b0;
		end else if (i_ce) begin
			pre_r  <= pre_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign o_tick = tick_r;
endmodule
`default_nettype wire

// File: logic/lrmon_evt_sel.sv
// Error event selector: picks the monitored event type.
`timescale 1ns/1ps
`default_nettype none
module lrmon_evt_sel (
	input  wire logic      i_mclk,
	input  wire logic      i_reset_n,
	input  wire logic      i_ce,
	input  wire logic      i_link_state_mode,
	input  wire logic      i_lcrc_err,
	input  wire logic      i_rec_entry,
	input  wire logic      i_rec_local,
	input  wire logic [3:0] i_rec_cause,
	output logic           o_event
);
	import lrmon_pkg::*;

	logic evt_r;
	logic evt_nxt;

	always_comb begin
		if (i_link_state_mode) begin
			// Only locally started recoveries with a listed cause count.
			evt_nxt = i_rec_entry && i_rec_local && (|i_rec_cause);
		end else begin
			evt_nxt = i_lcrc_err;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			evt_r <= 1'b0;
		end else if (i_ce) begin
			evt_r <= evt_nxt;
		end
	end

	assign o_event = evt_r;
endmodule
`default_nettype wire

// File: sim/lrmon_assertions.sv
// Port checker for the link reliability monitor.
`timescale 1ns/1ps
`default_nettype none
module lrmon_checker
	import lrmon_pkg::*;
(
	input wire logic        i_mclk,
	input wire logic        i_reset_n,
	input wire logic        i_sticky_reset_n,
	input wire logic        i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic        i_hready,
	input wire logic [31:0] o_hrdata,
	input wire logic        o_hreadyout,
	input wire logic        o_hresp,
	input wire logic        i_lcrc_err,
	input wire logic        i_rec_entry,
	input wire logic        i_rec_local,
	input wire logic [3:0]  i_rec_cause,
	input wire logic        o_unreliable_link
);
	// ==========================================================
	// Shadow of the control bits, rebuilt from the bus writes.
	logic        ph_wr_r, ph_wr_nxt, en_r, en_nxt, ty_r, ty_nxt;
	logic [11:0] ph_a_r, ph_a_nxt;
	wire logic   w1c = ph_wr_r && ph_a_r == LRMON_STAT_OFS && i_hwdata[0];
	wire logic   hit = i_rec_entry && i_rec_local && (|i_rec_cause);
	always_comb begin
		ph_wr_nxt = i_hsel && i_hready && i_htrans[1] && i_hwrite;
		ph_a_nxt = i_haddr[11:0];
		en_nxt = en_r;
		ty_nxt = ty_r;
		if (ph_wr_r && ph_a_r == LRMON_CTRL_OFS) begin
			en_nxt = i_hwdata[LRMON_EN_BIT];
			ty_nxt = i_hwdata[LRMON_TYPE_BIT];
		end
	end
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ph_wr_r <= 1'b0;
			ph_a_r <= 12'h000;
		end else begin
			ph_wr_r <= ph_wr_nxt;
			ph_a_r <= ph_a_nxt;
		end
	end
	always_ff @(posedge i_mclk or negedge i_sticky_reset_n) begin
		if (!i_sticky_reset_n) begin
			en_r <= 1'b0;
			ty_r <= 1'b0;
		end else begin
			en_r <= en_nxt;
			ty_r <= ty_nxt;
		end
	end
	// ==========================================================
	// Properties.
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	sequence s_rd(logic [11:0] a);
		i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_haddr[11:0] == a;
	endsequence
	a_bus_okay: assert property (o_hresp == 1'b0 && o_hreadyout == 1'b1)
		else $error("bus answer not zero-wait OKAY");
	a_unmapped_zero: assert property (s_rd(12'h57c) |=> o_hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl_readback: assert property (
		s_rd(LRMON_CTRL_OFS) |=> o_hrdata == {30'h0, ty_r, en_r})
		else $error("control readback wrong");
	a_flag_needs_en: assert property ($rose(o_unreliable_link) |-> $past(en_r))
		else $error("flag set while disabled");
	a_flag_holds: assert property (o_unreliable_link && !w1c |=> o_unreliable_link)
		else $error("flag dropped without write one");
	a_lcrc_cause: assert property ($rose(o_unreliable_link) && !ty_r |->
		$past(i_lcrc_err, 2) || $past(i_lcrc_err, 3) || $past(i_lcrc_err, 4))
		else $error("flag rose without recent lcrc error");
	a_state_cause: assert property ($rose(o_unreliable_link) && ty_r |->
		$past(hit, 2) || $past(hit, 3) || $past(hit, 4))
		else $error("flag rose without local recovery");
	a_sticky_reset: assert property (disable iff (1'b0)
		!i_sticky_reset_n |-> !o_unreliable_link)
		else $error("flag high in sticky reset");
endmodule
`default_nettype wire

// File: sim/lrmon_link_partner.sv
// Behavioural far side: error pulses, recovery entries and retrain requests.
`timescale 1ns/1ps
`default_nettype none
module lrmon_link_partner (
	input  wire logic i_mclk,
	output logic      o_lcrc_err,
	output logic      o_rec_entry,
	output logic      o_rec_local,
	output logic [3:0] o_rec_cause,
	output logic      o_retrain_req,
	output logic      o_in_detect
);
	initial begin
		o_lcrc_err = 1'b0;
		o_rec_entry = 1'b0;
		o_rec_local = 1'b0;
		o_rec_cause = 4'h0;
		o_retrain_req = 1'b0;
		o_in_detect = 1'b0;
	end
	// A gap of zero keeps the line high, one error per cycle.
	task automatic lcrc(input int n, input int gap);
		repeat (n) begin
			@(posedge i_mclk);
			o_lcrc_err <= 1'b1;
			repeat (gap) begin
				@(posedge i_mclk);
				o_lcrc_err <= 1'b0;
			end
		end
		@(posedge i_mclk);
		o_lcrc_err <= 1'b0;
		repeat (6) @(posedge i_mclk);
	endtask
	// Idle qualifiers show the inverse of their last value, never a stale copy.
	task automatic rec(input logic loc, input logic [3:0] cause);
		@(posedge i_mclk);
		o_rec_entry <= 1'b1;
		o_rec_local <= loc;
		o_rec_cause <= cause;
		@(posedge i_mclk);
		o_rec_entry <= 1'b0;
		o_rec_local <= !loc;
		o_rec_cause <= ~cause;
		repeat (6) @(posedge i_mclk);
	endtask
	task automatic clr(input logic det);
		@(posedge i_mclk);
		o_in_detect <= det;
		o_retrain_req <= !det;
		@(posedge i_mclk);
		o_in_detect <= 1'b0;
		o_retrain_req <= 1'b0;
		repeat (4) @(posedge i_mclk);
	endtask
endmodule
`default_nettype wire

// File: sim/test_lrmon_top.sv
// Self-checking testbench of the link reliability monitor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
	$display("unexpected at %0t: got %h want %h", $time, a, e); end end
module test_lrmon_top;
	import lrmon_pkg::*;
	logic        i_mclk = 0, i_reset_n, i_sticky_reset_n, i_ce = 1;
	logic        i_hsel = 0, i_hwrite = 0, o_hreadyout, o_hresp;
	logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, r;
	logic [1:0]  i_htrans = 0;
	logic [2:0]  i_hsize = 3'h2;
	logic        i_lcrc_err, i_rec_entry, i_rec_local, i_retrain_req, i_in_detect;
	logic [3:0]  i_rec_cause;
	logic        o_unreliable_link;
	int          err_total = 0, n_compared = 0;
	always #2.5 i_mclk = ~i_mclk;
	lrmon_top u_lrmon_top (.i_mclk, .i_reset_n, .i_sticky_reset_n, .i_ce,
		.i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
		.i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_lcrc_err,
		.i_rec_entry, .i_rec_local, .i_rec_cause, .i_retrain_req, .i_in_detect,
		.o_unreliable_link);
	lrmon_link_partner u_lrmon_link_partner (.i_mclk, .o_lcrc_err(i_lcrc_err),
		.o_rec_entry(i_rec_entry), .o_rec_local(i_rec_local), .o_rec_cause(i_rec_cause),
		.o_retrain_req(i_retrain_req), .o_in_detect(i_in_detect));
	// ==========================================================
	// Bus tasks and closing.
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_hsel <= 1'b1;
		i_htrans <= LRMON_HTRANS_NONSEQ;
		i_haddr <= {20'h0, a};
		i_hwrite <= w;
		@(posedge i_mclk);
		while (o_hreadyout !== 1'b1) @(posedge i_mclk);
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= d;
		@(posedge i_mclk);
		while (o_hreadyout !== 1'b1) @(posedge i_mclk);
		r = o_hrdata;
		i_hwdata <= ~d;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		acc(1'b0, a, 32'h0);
		`CHK(r & m, e)
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_mclk);
		err_total++;
		give_verdict();
	end
	// ==========================================================
	// Tests.
	initial begin
		// Driving the resets from unknown to low gives the flops a real reset edge.
		i_reset_n <= 1'b0;
		i_sticky_reset_n <= 1'b0;
		repeat (6) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		i_sticky_reset_n <= 1'b1;
		rc(LRMON_CTRL_OFS, 32'h0, '1);
		rc(LRMON_STAT_OFS, 32'h0, '1);
		rc(LRMON_THRESH_OFS, 32'hffff_ffff, '1);
		rc(LRMON_CNT_OFS, 32'h0, 32'hff);
		rc(12'h57c, 32'h0, '1);
		$display("test reset values done");
		wr(LRMON_THRESH_OFS, {24'd20, 8'h03});
		u_lrmon_link_partner.lcrc(3, 3);
		rc(LRMON_STAT_OFS, 32'h0, '1);
		rc(LRMON_CNT_OFS, 32'h3, 32'hff);
		i_ce <= 1'b0;
		u_lrmon_link_partner.lcrc(2, 0);
		i_ce <= 1'b1;
		rc(LRMON_CNT_OFS, 32'h3, 32'hff);
		$display("test disabled done");
		wr(LRMON_CTRL_OFS, 32'h1);
		rc(LRMON_CNT_OFS, 32'h0, 32'hff);
		u_lrmon_link_partner.lcrc(2, 0);
		rc(LRMON_STAT_OFS, 32'h0, '1);
		u_lrmon_link_partner.lcrc(1, 0);
		rc(LRMON_STAT_OFS, 32'h1, '1);
		`CHK(o_unreliable_link, 1'b1)
		u_lrmon_link_partner.lcrc(2, 0);
		rc(LRMON_CNT_OFS, 32'h3, 32'hff);
		$display("test lcrc threshold done");
		u_lrmon_link_partner.clr(1'b0);
		rc(LRMON_CNT_OFS, 32'h0, 32'hff);
		rc(LRMON_STAT_OFS, 32'h1, '1);
		wr(LRMON_STAT_OFS, 32'h0);
		rc(LRMON_STAT_OFS, 32'h1, '1);
		wr(LRMON_STAT_OFS, 32'h1);
		rc(LRMON_STAT_OFS, 32'h0, '1);
		$display("test clear done");
		wr(LRMON_THRESH_OFS, {24'd20, 8'h04});
		wr(LRMON_CTRL_OFS, 32'h3);
		u_lrmon_link_partner.rec(1'b0, 4'h1);
		u_lrmon_link_partner.lcrc(1, 0);
		rc(LRMON_CNT_OFS, 32'h0, 32'hff);
		for (int c = 0; c < 4; c++) begin
			u_lrmon_link_partner.rec(1'b1, 4'h1 << c);
			rc(LRMON_CNT_OFS, 32'(c + 1), 32'hff);
		end
		rc(LRMON_STAT_OFS, 32'h1, '1);
		$display("test link state done");
		u_lrmon_link_partner.clr(1'b1);
		rc(LRMON_CNT_OFS, 32'h0, 32'hff);
		wr(LRMON_STAT_OFS, 32'h1);
		wr(LRMON_CTRL_OFS, 32'h0);
		wr(LRMON_THRESH_OFS, {24'd1, 8'h04});
		u_lrmon_link_partner.lcrc(2, 3);
		repeat (500) @(posedge i_mclk);
		rc(LRMON_CNT_OFS, 32'h0, 32'hff);
		`CHK(r[31:8] <= 24'd1, 1'b1)
		$display("test window restart done");
		wr(LRMON_CTRL_OFS, 32'h2);
		@(posedge i_mclk);
		i_reset_n <= 1'b0;
		repeat (6) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		rc(LRMON_CTRL_OFS, 32'h2, '1);
		rc(LRMON_THRESH_OFS, {24'd1, 8'h04}, '1);
		$display("test sticky done");
		give_verdict();
	end
endmodule
bind lrmon_top lrmon_checker u_lrmon_checker (.i_mclk, .i_reset_n, .i_sticky_reset_n,
	.i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hrdata,
	.o_hreadyout, .o_hresp, .i_lcrc_err, .i_rec_entry, .i_rec_local, .i_rec_cause,
	.o_unreliable_link);
`default_nettype wire
